// >>> logic/ulsr_cfg.svh
// Constants of the UART mode block: counts, reset values, depths.
// Assumes inclusion by the serdes and top files of the block; definitions only.
`ifndef ULSR_CFG_SVH
`define ULSR_CFG_SVH

// ==========================================================
// Character framing
`define ULSR_DATA_BITS     8
`define ULSR_OS_COUNT      16
`define ULSR_OS_LAST       4'hF
`define ULSR_OS_MID        4'h7
`define ULSR_BIT_LAST      3'h7
`define ULSR_BITS_PER_CHAR 11

// ==========================================================
// Sleep entry: receive line idle for this many characters
`define ULSR_IDLE_CHARS    4
`define ULSR_IDLE_TICKS    10'(`ULSR_IDLE_CHARS * `ULSR_BITS_PER_CHAR * `ULSR_OS_COUNT)

// ==========================================================
// Buffering and reset values
`define ULSR_FIFO_DEPTH    4
`define ULSR_DIV_MIN       16'h0001
`define ULSR_RX_EN_RST     1'b1

`endif

// >>> logic/ulsr_pkg.sv
// Types shared by the UART mode block.
// Assumes nothing beyond a SystemVerilog compiler.
package ulsr_pkg;

  // ==========================================================
  // Transmit and receive sequencer states, one-hot
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } ulsr_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } ulsr_rx_state_t;

endpackage

// >>> logic/ulsr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module ulsr_fifo import ulsr_pkg::*; #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Elaboration check
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("ulsr_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  // Storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// >>> logic/ulsr_serdes.sv
// Serializer and deserializer for one character: start, 8 data,
// optional parity/address bit, one stop. Runs on a 16x tick.
// Assumes the tick is a one-cycle pulse from the baud divider.
`timescale 1ns/10ps
`include "ulsr_cfg.svh"
module ulsr_serdes import ulsr_pkg::*; (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  input  wire logic       par_en,
  input  wire logic       load_valid,
  output logic            load_ready,
  input  wire logic [8:0] load_data,
  output logic            tx_out,
  output logic            tx_busy,
  input  wire logic       rx_in,
  output logic            rx_done,
  output logic      [7:0] rx_data,
  output logic            rx_par,
  output logic            rx_frame_err
);
  ulsr_tx_state_t tx_state_reg;
  ulsr_rx_state_t rx_state_reg;
  logic [3:0]     tx_os_reg;
  logic [2:0]     tx_bit_reg;
  logic [8:0]     tx_shift_reg;
  logic [3:0]     rx_os_reg;
  logic [2:0]     rx_bit_reg;
  logic           tx_last;
  logic           rx_last;

  assign load_ready = tx_state_reg == TX_IDLE;
  assign tx_busy    = tx_state_reg != TX_IDLE;
  assign tx_last    = tick && tx_os_reg == `ULSR_OS_LAST;
  assign rx_last    = tick && rx_os_reg == `ULSR_OS_LAST;

  // ==========================================================
  // Transmit sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_state_reg <= TX_IDLE;
      tx_os_reg    <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 9'h000;
    end else begin
      if (tick) tx_os_reg <= tx_os_reg + 4'h1;
      case (tx_state_reg)
        TX_IDLE: if (load_valid) begin
          tx_shift_reg <= load_data;
          tx_os_reg    <= 4'h0;
          tx_state_reg <= TX_START;
        end
        TX_START: if (tx_last) begin
          tx_bit_reg   <= 3'h0;
          tx_state_reg <= TX_DATA;
        end
        TX_DATA: if (tx_last) begin
          tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
          tx_bit_reg   <= tx_bit_reg + 3'h1;
          if (tx_bit_reg == `ULSR_BIT_LAST) tx_state_reg <= par_en ? TX_PAR : TX_STOP;
        end
        TX_PAR:  if (tx_last) tx_state_reg <= TX_STOP;
        TX_STOP: if (tx_last) tx_state_reg <= TX_IDLE;
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Line level registered so the pin never glitches
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_out <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_START: tx_out <= 1'b0;
        TX_DATA:  tx_out <= tx_shift_reg[0];
        TX_PAR:   tx_out <= tx_shift_reg[0];
        default:  tx_out <= 1'b1;
      endcase
    end
  end

  // ==========================================================
  // Receive sequencer, samples at bit centres
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_state_reg <= RX_IDLE;
      rx_os_reg    <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_data      <= 8'h00;
      rx_par       <= 1'b0;
      rx_frame_err <= 1'b0;
      rx_done      <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) rx_os_reg <= rx_os_reg + 4'h1;
      case (rx_state_reg)
        RX_IDLE: if (tick && !rx_in) begin
          rx_os_reg    <= 4'h0;
          rx_state_reg <= RX_START;
        end
        RX_START: if (tick && rx_os_reg == `ULSR_OS_MID) begin
          // A short low pulse is noise, not a start bit
          rx_os_reg    <= 4'h0;
          rx_bit_reg   <= 3'h0;
          rx_state_reg <= rx_in ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_last) begin
          rx_data    <= {rx_in, rx_data[7:1]};
          rx_bit_reg <= rx_bit_reg + 3'h1;
          if (rx_bit_reg == `ULSR_BIT_LAST) rx_state_reg <= par_en ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rx_last) begin
          rx_par       <= rx_in;
          rx_state_reg <= RX_STOP;
        end
        RX_STOP: if (rx_last) begin
          rx_frame_err <= !rx_in;
          rx_done      <= 1'b1;
          if (!par_en) rx_par <= 1'b0;
          rx_state_reg <= RX_IDLE;
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end
endmodule

// >>> logic/ulsr_top.sv
// One UART channel's operating-mode logic: loopback, automatic
// sleep, low power, auto RS-485 direction and 9-bit multi-drop.
// Assumes all pins and config ports are synchronous to core_clk;
// modem pins are active low, request-to-send too unless rs485_invert is set in auto RS-485 mode.
`timescale 1ns/10ps
`include "ulsr_cfg.svh"
module ulsr_top import ulsr_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Host data path
  input  wire logic        tx_wr_valid,
  output logic             tx_wr_ready,
  input  wire logic [8:0]  tx_wr_data,
  output logic             rx_rd_valid,
  input  wire logic        rx_rd_ready,
  output logic      [7:0]  rx_rd_data,
  output logic             rx_rd_parity_err,
  output logic             rx_rd_frame_err,
  // Configuration bits
  input  wire logic [15:0] divisor,
  input  wire logic        parity_en,
  input  wire logic        mcr_dtr,
  input  wire logic        mcr_rts,
  input  wire logic        user_output_one,
  input  wire logic        user_output_two,
  input  wire logic        loopback_en,
  input  wire logic        enh_func_en,
  input  wire logic        special_char_en,
  input  wire logic        sleep_en_own,
  input  wire logic        sleep_en_other,
  input  wire logic        sleep_ignore_rx,
  input  wire logic        hw_flow_en,
  input  wire logic        hw_flow_rts,
  input  wire logic        auto_rs485_en,
  input  wire logic        rs485_invert,
  input  wire logic        nine_bit_en,
  input  wire logic [7:0]  second_stop_char_reg,
  input  wire logic        rx_enable_set,
  input  wire logic        rx_enable_clr,
  input  wire logic        irq_pending,
  // Status
  output logic             rx_enabled,
  output logic             asleep,
  output logic             low_power_active,
  output logic      [3:0]  modem_status,
  output logic             modem_change,
  output logic             line_status_event,
  output logic             rx_overrun_event,
  output logic             irq_out,
  output logic             irq_oe,
  // Serial and modem pins
  input  wire logic        low_power_pin,
  input  wire logic        serial_receive_pins,
  output logic             serial_transmit_pin,
  input  wire logic        cts_n_pin,
  input  wire logic        dsr_n_pin,
  input  wire logic        cd_n_pin,
  input  wire logic        ri_n_pin,
  output logic             request_to_send_pin,
  output logic             dtr_n_pin,
  output logic             user_output_one_n,
  output logic             user_output_two_n
);

  // ==========================================================
  // Declarations
  logic        low_power_reg;
  logic        asleep_reg;
  logic        asleep_next;
  logic        clk_run;
  logic [15:0] div_cnt_reg;
  logic [15:0] div_eff;
  logic        baud_tick_reg;
  logic [9:0]  idle_cnt_reg;
  logic        rx_idle;
  logic [3:0]  modem_pins_reg;
  logic [3:0]  modem_pins;
  logic        pin_change;
  logic        sleep_allowed;
  logic        entry_ok;
  logic        wake;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [8:0]  fifo_out_data;
  logic        fifo_in_ready;
  logic        ser_load_ready;
  logic [8:0]  ser_load_data;
  logic        tx_serial;
  logic        tx_busy;
  logic        rx_line;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_par;
  logic        rx_frame_err;
  logic        is_addr;
  logic        addr_match;
  logic        par_mismatch;
  logic        store;
  logic        store_pe;
  logic        lsi;
  logic        hw_rx_set;
  logic        hw_rx_clr;
  logic        rx_en_reg;
  logic        hold_valid_reg;
  logic        rts_active;

  // ==========================================================
  // Low power and clock run control
  // Pin is sampled once; everything but irq_oe gated by the registered level
  always_ff @(posedge core_clk) begin
    if (sys_rst) low_power_reg <= 1'b0;
    else         low_power_reg <= low_power_pin;
  end

  // Stopping the baud tick freezes every character sequencer
  assign clk_run          = !asleep_reg && !low_power_reg;
  assign low_power_active = low_power_reg;
  assign asleep           = asleep_reg;

  // ==========================================================
  // Baud divider, 16x tick
  // A zero divisor would never tick; treated as one
  assign div_eff = (divisor == 16'h0000) ? `ULSR_DIV_MIN : divisor;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_cnt_reg   <= 16'h0000;
      baud_tick_reg <= 1'b0;
    end else begin
      baud_tick_reg <= 1'b0;
      if (clk_run) begin
        if (div_cnt_reg >= div_eff - `ULSR_DIV_MIN) begin
          div_cnt_reg   <= 16'h0000;
          baud_tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // Modem inputs and loopback rerouting
  assign modem_pins = {~cd_n_pin, ~ri_n_pin, ~dsr_n_pin, ~cts_n_pin};
  assign pin_change = modem_pins != modem_pins_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) modem_pins_reg <= 4'h0;
    else         modem_pins_reg <= modem_pins;
  end

  // Internal CD, RI, DSR, CTS come from the own outputs in loopback
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      modem_status <= 4'h0;
      modem_change <= 1'b0;
    end else begin
      modem_change <= pin_change && !loopback_en;
      if (loopback_en) begin
        modem_status <= {user_output_two, user_output_one, mcr_dtr, mcr_rts};
      end else begin
        modem_status <= modem_pins;
      end
    end
  end

  // DTR and both user outputs go inactive while looped back; RTS is not forced
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dtr_n_pin         <= 1'b1;
      user_output_one_n <= 1'b1;
      user_output_two_n <= 1'b1;
    end else begin
      dtr_n_pin         <= loopback_en || !mcr_dtr;
      user_output_one_n <= loopback_en || !user_output_one;
      user_output_two_n <= loopback_en || !user_output_two;
    end
  end

  // Floated interrupt: host has to poll status in loopback
  // Pin read directly so the float lands with low_power_active
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else begin
      irq_out <= irq_pending;
      irq_oe  <= !loopback_en && !low_power_pin;
    end
  end

  // ==========================================================
  // Transmit path: FIFO then serializer
  assign tx_wr_ready = fifo_in_ready && !low_power_reg;

  ulsr_fifo #(
    .WIDTH (9),
    .DEPTH (`ULSR_FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (tx_wr_valid && !low_power_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (tx_wr_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Serializer only takes a word while clocks run
  assign fifo_out_ready = ser_load_ready && clk_run;
  // Bit 8 is the address flag in 9-bit mode, else even parity
  assign ser_load_data  = {nine_bit_en ? fifo_out_data[8] : ^fifo_out_data[7:0],
                           fifo_out_data[7:0]};

  // Loopback joins the real serializer to the real receiver
  assign rx_line = loopback_en ? tx_serial : serial_receive_pins;

  ulsr_serdes u_serdes (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .tick         (baud_tick_reg),
    .par_en       (parity_en || nine_bit_en),
    .load_valid   (fifo_out_valid && clk_run),
    .load_ready   (ser_load_ready),
    .load_data    (ser_load_data),
    .tx_out       (tx_serial),
    .tx_busy      (tx_busy),
    .rx_in        (rx_line),
    .rx_done      (rx_done),
    .rx_data      (rx_data),
    .rx_par       (rx_par),
    .rx_frame_err (rx_frame_err)
  );

  // Pin held at idle mark while looped back
  always_ff @(posedge core_clk) begin
    if (sys_rst) serial_transmit_pin <= 1'b1;
    else         serial_transmit_pin <= loopback_en || tx_serial;
  end

  // ==========================================================
  // Request-to-send pin
  // Active from the FIFO write until the stop bit has gone out
  assign rts_active = fifo_out_valid || tx_busy;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      request_to_send_pin <= 1'b1;
    end else if (auto_rs485_en) begin
      request_to_send_pin <= rs485_invert ? rts_active : !rts_active;
    end else if (hw_flow_en) begin
      request_to_send_pin <= !hw_flow_rts;
    end else begin
      request_to_send_pin <= !mcr_rts;
    end
  end

  // ==========================================================
  // Receive acceptance and multi-drop decisions
  assign is_addr      = nine_bit_en && rx_par;
  assign addr_match   = rx_data == second_stop_char_reg;
  assign par_mismatch = parity_en && (rx_par != ^rx_data);

  always_comb begin
    store     = 1'b0;
    store_pe  = 1'b0;
    lsi       = 1'b0;
    hw_rx_set = 1'b0;
    hw_rx_clr = 1'b0;
    if (!nine_bit_en) begin
      store    = rx_en_reg;
      store_pe = par_mismatch;
      lsi      = rx_en_reg && (par_mismatch || rx_frame_err);
    end else if (special_char_en) begin
      if (is_addr && addr_match) begin
        store     = 1'b1;
        store_pe  = rx_par;
        lsi       = 1'b1;
        hw_rx_set = 1'b1;
      end else if (is_addr) begin
        hw_rx_clr = 1'b1;
      end else begin
        store = rx_en_reg;
      end
    end else begin
      // Address flagged as parity error whatever the enable
      if (is_addr) begin
        store    = 1'b1;
        store_pe = 1'b1;
        lsi      = 1'b1;
      end else begin
        store = rx_en_reg;
      end
    end
  end

  // Hardware enable beats host clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_en_reg <= `ULSR_RX_EN_RST;
    end else if ((rx_done && hw_rx_set) || rx_enable_set) begin
      rx_en_reg <= 1'b1;
    end else if ((rx_done && hw_rx_clr) || rx_enable_clr) begin
      rx_en_reg <= 1'b0;
    end
  end

  assign rx_enabled = rx_en_reg;

  // Single holding word; a new character while full is lost
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hold_valid_reg    <= 1'b0;
      rx_rd_data        <= 8'h00;
      rx_rd_parity_err  <= 1'b0;
      rx_rd_frame_err   <= 1'b0;
      line_status_event <= 1'b0;
      rx_overrun_event  <= 1'b0;
    end else begin
      line_status_event <= rx_done && lsi;
      rx_overrun_event  <= rx_done && store && hold_valid_reg && !(rx_rd_valid && rx_rd_ready);
      if (rx_done && store && (!hold_valid_reg || (rx_rd_valid && rx_rd_ready))) begin
        hold_valid_reg   <= 1'b1;
        rx_rd_data       <= rx_data;
        rx_rd_parity_err <= store_pe;
        rx_rd_frame_err  <= rx_frame_err;
      end else if (rx_rd_valid && rx_rd_ready) begin
        hold_valid_reg <= 1'b0;
      end
    end
  end

  assign rx_rd_valid = hold_valid_reg && !low_power_reg;

  // ==========================================================
  // Receive line idle timer for sleep entry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idle_cnt_reg <= 10'h000;
    end else if (baud_tick_reg) begin
      if (!rx_line) idle_cnt_reg <= 10'h000;
      else if (idle_cnt_reg != `ULSR_IDLE_TICKS) idle_cnt_reg <= idle_cnt_reg + 10'h001;
    end
  end

  assign rx_idle = idle_cnt_reg == `ULSR_IDLE_TICKS;

  // ==========================================================
  // Automatic sleep
  assign sleep_allowed = enh_func_en && sleep_en_own && sleep_en_other;
  assign entry_ok = !pin_change && (rx_idle || sleep_ignore_rx) && !fifo_out_valid
                 && !tx_busy && !irq_pending && !hold_valid_reg;
  // Start bit seen as a low receive pin, so wake is immediate
  assign wake = !serial_receive_pins || tx_wr_valid || pin_change;

  always_comb begin
    if (!sleep_allowed) begin
      asleep_next = 1'b0;
    end else begin
      asleep_next = entry_ok && !wake;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) asleep_reg <= 1'b0;
    else         asleep_reg <= asleep_next;
  end

  // Divisor changes are the host's burden while asleep
  // and are simply taken when clocks run again.
endmodule

// >>> test/ulsr_monitor.sv
// Port checker for the UART mode block.
// Assumes it is bound into every ulsr_top instance.
`timescale 1ns/10ps
module ulsr_monitor (
  input wire logic       core_clk, sys_rst, loopback_en, irq_oe, serial_transmit_pin, mcr_rts, mcr_dtr,
  input wire logic       user_output_one, user_output_two, auto_rs485_en, rs485_invert, hw_flow_en,
  input wire logic       tx_wr_valid, tx_wr_ready, rx_rd_valid, request_to_send_pin, low_power_pin,
  input wire logic       low_power_active, asleep, enh_func_en, sleep_en_own, sleep_en_other, irq_pending,
  input wire logic [3:0] modem_status
);
  // ==========================================================
  // Relations sampled on the core clock, muted in reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  irq_float_a: assert property (loopback_en |=> !irq_oe) else $error("irq driven in loopback");
  tx_detach_a: assert property (loopback_en |=> serial_transmit_pin) else $error("tx pin active");
  modem_route_a: assert property (loopback_en ##1 loopback_en |-> modem_status ==
    {$past(user_output_two), $past(user_output_one), $past(mcr_dtr), $past(mcr_rts)}) else $error("modem route");
  rts_manual_a: assert property (!auto_rs485_en && !hw_flow_en && !low_power_active
    |=> request_to_send_pin == !$past(mcr_rts)) else $error("rts not from modem bit");
  rts_auto_a: assert property (auto_rs485_en && tx_wr_valid && tx_wr_ready
    |-> ##[1:3] request_to_send_pin == rs485_invert) else $error("rts not turned");
  lp_enter_a: assert property (low_power_pin |=> low_power_active) else $error("low power late");
  lp_block_a: assert property (low_power_active |-> !tx_wr_ready && !rx_rd_valid && !irq_oe) else $error("lp");
  sleep_gate_a: assert property ($rose(asleep)
    |-> $past(enh_func_en && sleep_en_own && sleep_en_other && !irq_pending)) else $error("bad sleep");
  // Scenario coverage
  cover property ($rose(asleep));
  cover property (loopback_en && $rose(rx_rd_valid));
  cover property (auto_rs485_en && $changed(request_to_send_pin));
endmodule
bind ulsr_top ulsr_monitor mon (.*);

// >>> test/ulsr_line_model.sv
// Remote station on the receive line.
// Assumes divisor 1, so one bit lasts 16 core cycles.
`timescale 1ns/10ps
module ulsr_line_model (
  input wire logic core_clk,
  output logic     rx_line
);
  // ==========================================================
  // Idle high as the pull-up leaves it
  initial rx_line = 1'b1;
  // Start, data LSB first, address bit, stop
  task automatic send(input logic [8:0] w);
    logic [10:0] f;
    f = {1'b1, w[8], w[7:0], 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line = f[i];
      repeat (16) @(negedge core_clk);
    end
  endtask
endmodule

// >>> test/test_ulsr_top.sv
// Self-checking bench for the UART mode block.
// Assumes the line model drives the receive pin.
`timescale 1ns/10ps
module test_ulsr_top;
  logic        core_clk, sys_rst, tx_wr_valid, tx_wr_ready, rx_rd_valid, rx_rd_ready, rx_rd_parity_err;
  logic        rx_rd_frame_err, parity_en, mcr_dtr, mcr_rts, user_output_one, user_output_two, loopback_en;
  logic        enh_func_en, special_char_en, sleep_en_own, sleep_en_other, sleep_ignore_rx, hw_flow_en;
  logic        hw_flow_rts, auto_rs485_en, rs485_invert, nine_bit_en, rx_enable_set, rx_enable_clr;
  logic        irq_pending, rx_enabled, asleep, low_power_active, modem_change, line_status_event, irq_out;
  logic        rx_overrun_event, irq_oe, low_power_pin, serial_receive_pins, serial_transmit_pin, cts_n_pin;
  logic        dsr_n_pin, cd_n_pin, ri_n_pin, request_to_send_pin, dtr_n_pin, user_output_one_n, user_output_two_n;
  logic [8:0]  tx_wr_data;
  logic [7:0]  rx_rd_data, second_stop_char_reg;
  logic [15:0] divisor;
  logic [3:0]  modem_status;
  int          errors = 0, n_checks = 0, cycles = 0;
  ulsr_top dut (.*);
  ulsr_line_model line (.core_clk(core_clk), .rx_line(serial_receive_pins));
  // ==========================================================
  // Clock and hang guard
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 9000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [8:0] w);
    tx_wr_data = w;
    tx_wr_valid = 1;
    for (int i = 0; i < 99 && tx_wr_ready !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    tx_wr_valid = 0;
  endtask
  // Wait for a word, compare valid, frame and parity flags and data, then take it
  task automatic get(input logic [8:0] exp);
    for (int i = 0; i < 400 && rx_rd_valid !== 1'b1; i++) @(negedge core_clk);
    chk({rx_rd_valid, rx_rd_frame_err, rx_rd_parity_err, rx_rd_data}, {2'h2, exp});
    rx_rd_ready = 1;
    @(negedge core_clk);
    rx_rd_ready = 0;
  endtask
  task automatic t_loop();
    {loopback_en, parity_en} = 2'h3;
    for (int k = 5; k < 11; k += 5) begin
      {user_output_two, user_output_one, mcr_dtr, mcr_rts} = k[3:0];
      repeat (3) @(negedge core_clk);
      chk(10'(modem_status), 10'(k[3:0]));
    end
    chk(10'(irq_oe), 10'h000);
    chk({dtr_n_pin, user_output_one_n, user_output_two_n, serial_transmit_pin}, 11'h00F);
    put(9'h05A);
    get(9'h05A);
    {loopback_en, parity_en, user_output_two, user_output_one, mcr_dtr, mcr_rts} = 6'h00;
    $display("loopback done");
  endtask
  task automatic t_rs485();
    for (int v = 0; v < 2; v++) begin
      auto_rs485_en = 1;
      rs485_invert = v[0];
      put(9'h0C3);
      repeat (2) @(negedge core_clk);
      chk(10'(request_to_send_pin), 10'(v[0]));
      repeat (200) @(negedge core_clk);
      chk(10'(request_to_send_pin), 10'(!v[0]));
    end
    {auto_rs485_en, hw_flow_en, hw_flow_rts} = 3'h3;
    repeat (2) @(negedge core_clk);
    chk(10'(request_to_send_pin), 10'h000);
    {hw_flow_en, hw_flow_rts} = 2'h0;
    $display("rs485 done");
  endtask
  // Flow control stays off through multi-drop
  task automatic t_nine();
    nine_bit_en = 1;
    rx_enable_clr = 1;
    @(negedge core_clk);
    rx_enable_clr = 0;
    line.send(9'h011);
    chk(10'(rx_rd_valid), 10'h000);
    line.send(9'h1A5);
    get(9'h1A5);
    rx_enable_set = 1;
    @(negedge core_clk);
    rx_enable_set = 0;
    line.send(9'h022);
    get(9'h022);
    line.send(9'h1A6);
    get(9'h1A6);
    {special_char_en, second_stop_char_reg} = 9'h133;
    line.send(9'h144);
    line.send(9'h055);
    chk({rx_rd_valid, rx_enabled}, 10'h000);
    line.send(9'h133);
    get(9'h133);
    chk(10'(rx_enabled), 10'h001);
    $display("nine bit done");
  endtask
  task automatic t_sleep();
    {enh_func_en, sleep_en_own, sleep_en_other, sleep_ignore_rx} = 4'hF;
    for (int i = 0; i < 50 && asleep !== 1'b1; i++) @(negedge core_clk);
    chk(10'(asleep), 10'h001);
    {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin} = 4'h0;
    @(negedge core_clk);
    chk({asleep, modem_change, modem_status}, 11'h01F);
    for (int i = 0; i < 50 && asleep !== 1'b1; i++) @(negedge core_clk);
    chk(10'(asleep), 10'h001);
    {sleep_en_other, irq_pending} = 2'h1;
    repeat (3) @(negedge core_clk);
    sleep_en_other = 1;
    repeat (30) @(negedge core_clk);
    chk({asleep, irq_out, irq_oe}, 11'h003);
    low_power_pin = 1;
    repeat (2) @(negedge core_clk);
    chk({low_power_active, tx_wr_ready}, 10'h002);
    {low_power_pin, irq_pending} = 2'h0;
    repeat (2) @(negedge core_clk);
    chk(10'(low_power_active), 10'h000);
    $display("sleep done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Reset for six cycles, then the scenarios; divisor never moves
  initial begin
    {core_clk, sys_rst, tx_wr_data, second_stop_char_reg, divisor} = {2'h1, 17'h00000, 16'h0001};
    {tx_wr_valid, rx_rd_ready, parity_en, mcr_dtr, mcr_rts, user_output_one, user_output_two} = 7'h00;
    {loopback_en, enh_func_en, special_char_en, sleep_en_own, sleep_en_other, sleep_ignore_rx} = 6'h00;
    {hw_flow_en, hw_flow_rts, auto_rs485_en, rs485_invert, nine_bit_en, rx_enable_set} = 6'h00;
    {rx_enable_clr, irq_pending, low_power_pin, cts_n_pin, dsr_n_pin, cd_n_pin, ri_n_pin} = 7'h0F;
    repeat (6) @(negedge core_clk);
    sys_rst = 0;
    t_loop();
    t_rs485();
    t_nine();
    t_sleep();
    finish_test();
  end
endmodule
